// ==== verilog/rdct_pkg.sv ====
// Package with register map, field layouts, encodings and reset values of the reload down-counter timer
package rdct_pkg;

    // Register byte addresses on the plain register port
    localparam logic [19:0] RDCT_ADDR_CTRL  = 20'hF_02A0;  // timer_control_status
    localparam logic [19:0] RDCT_ADDR_IO    = 20'hF_02A1;  // timer_io_control
    localparam logic [19:0] RDCT_ADDR_MODE  = 20'hF_02A2;  // timer_mode_select
    localparam logic [19:0] RDCT_ADDR_COUNT = 20'hF_02A8;  // timer_count_reload

    // Reset values
    localparam logic [15:0] RDCT_COUNT_RESET = 16'hFFFF;
    localparam logic [7:0]  RDCT_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  RDCT_IO_RESET    = 8'h00;
    localparam logic [7:0]  RDCT_MODE_RESET  = 8'h00;

    // Bit positions in timer_control_status
    localparam int RDCT_BIT_START = 0;  // count_start_bit
    localparam int RDCT_BIT_CSTAT = 1;  // count_status_flag
    localparam int RDCT_BIT_STOP  = 2;  // forced_stop_bit
    localparam int RDCT_BIT_EDGF  = 4;  // active_edge_flag
    localparam int RDCT_BIT_UNDF  = 5;  // underflow_flag

    // Prescaler width: the slowest derived rate is one thirty-second of the clock
    localparam int RDCT_PRESC_W = 5;
    // Matching samples needed by the event pin filter
    localparam int RDCT_FILTER_SAMPLES = 3;

    // Operating modes
    localparam logic [2:0] RDCT_MODE_TIMER  = 3'h0;
    localparam logic [2:0] RDCT_MODE_PULSE  = 3'h1;
    localparam logic [2:0] RDCT_MODE_EVENT  = 3'h2;
    localparam logic [2:0] RDCT_MODE_WIDTH  = 3'h3;
    localparam logic [2:0] RDCT_MODE_PERIOD = 3'h4;

    // Count sources
    localparam logic [2:0] RDCT_SRC_CLK    = 3'h0;
    localparam logic [2:0] RDCT_SRC_DIV8   = 3'h1;
    localparam logic [2:0] RDCT_SRC_DIV2   = 3'h3;
    localparam logic [2:0] RDCT_SRC_LOWOSC = 3'h4;
    localparam logic [2:0] RDCT_SRC_LINK   = 3'h5;
    localparam logic [2:0] RDCT_SRC_SUB    = 3'h6;

    // Count gate windows (event count mode)
    localparam logic [1:0] RDCT_GATE_ALWAYS = 2'h0;
    localparam logic [1:0] RDCT_GATE_EXTINT = 2'h1;
    localparam logic [1:0] RDCT_GATE_TIMER  = 2'h2;

    // Filter sampling codes
    localparam logic [1:0] RDCT_FILT_NONE  = 2'h0;
    localparam logic [1:0] RDCT_FILT_CLK   = 2'h1;
    localparam logic [1:0] RDCT_FILT_DIV8  = 2'h2;
    localparam logic [1:0] RDCT_FILT_DIV32 = 2'h3;

    // Layout of timer_io_control
    typedef struct packed {
        logic [1:0] count_gate_select;
        logic [1:0] input_filter_select;
        logic       rsvd3;
        logic       pulse_output_enable;
        logic       rsvd1;
        logic       io_polarity_select;
    } rdct_io_t;

    // Layout of timer_mode_select
    typedef struct packed {
        logic       rsvd7;
        logic [2:0] count_source_select;
        logic       edge_count_select;
        logic [2:0] operating_mode_field;
    } rdct_mode_t;

    // One register port access
    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rdct_bus_t;

endpackage

// ==== verilog/rdct_timer.sv ====
// Reload down-counter timer channel with register port, count sources, input filter and pulse outputs
`timescale 1ns/1ns

// Behaviour
// - Counter register writes reload, reads live count
// - Reset sets reload value and counter to ones
// - Forced stop halts and loads all ones
// - Forced stop clears start, status; pins to initial level; reads zero
// - Zero reload, non-divided source: one request only
// - Event mode zero reload: one request only
// - Otherwise request on every underflow
// - Counter register access costs one wait clock
// - Underflow sets flag bit 5 until zero written
// - Measurement end sets edge flag bit 4
// - Status follows start on tick; stop clears
// - Gate field selects event counting window
// - Filter samples at chosen rate, three matches
// - Output enable drives pulse pin, else released
// - Polarity bit meaning depends on mode
// - Polarity bit sets pulse pin initial level
// - Source select picks the count source
// - Edge select zero counts single edge
// - Mode field selects one of five modes
// - Running writes: reload, then counter, on ticks
// - Decrement per tick; underflow reloads, interrupts
module rdct_timer
    import rdct_pkg::*;
#(
    parameter int FILTER_SAMPLES = RDCT_FILTER_SAMPLES  // Matching samples for the event pin filter
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_N_I,
    // Register port
    input  wire logic [19:0] REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [15:0] REG_RDATA_O,
    output logic             BUS_WAIT_O,
    // Count sources from the clock system and event link
    input  wire logic        LOW_SPEED_OSC_I,
    input  wire logic        SUB_CLK_I,
    input  wire logic        LINK_EVENT_I,
    // Count window sources for event count mode
    input  wire logic        EXT_INT_I,
    input  wire logic        GATE_TIMER_OUT_I,
    input  wire logic        GATE_POLARITY_I,
    // Event I/O pin, split into input, output and output enable
    input  wire logic        EVENT_IO_I,
    output logic             EVENT_IO_O,
    output logic             EVENT_IO_OE_N_O,
    // Pulse output pin
    output logic             PULSE_OUT_O,
    output logic             PULSE_OUT_OE_N_O,
    // Requests to the interrupt, transfer and event link logic
    output logic             TIMER_IRQ_O,
    output logic             XFER_REQ_O
);

    // Refuse filter depths the shift register cannot serve
    if (FILTER_SAMPLES < 2 || FILTER_SAMPLES > 8) begin : g_bad_filter
        $error("rdct_timer: FILTER_SAMPLES must be 2 to 8");
    end

    // Register state
    logic [15:0] reload;          // Reload register
    logic [15:0] counter;         // Live down-counter
    logic [15:0] reload_hold;     // Write value waiting for a tick while running
    logic [1:0]  wr_stage;        // 0 idle, 1 reload pending, 2 counter pending
    logic        start;           // count_start_bit
    logic        count_status;    // count_status_flag
    logic        underflow_flag;  // underflow_flag
    logic        edge_flag;       // active_edge_flag
    rdct_io_t    io_ctl;          // timer_io_control
    rdct_mode_t  mode_sel;        // timer_mode_select
    logic        toggle;          // Pulse toggle flip-flop, zero means initial level
    logic        req_done;        // A zero-reload request was already given this run

    // Prescaler and edge history
    logic [RDCT_PRESC_W-1:0]   presc;        // Free-running divider
    logic                      low_osc_q;    // Previous low-speed oscillator level
    logic                      sub_clk_q;    // Previous sub clock level
    logic [FILTER_SAMPLES-1:0] filt_shift;   // Filter samples, newest in bit 0
    logic                      pin_level;    // Accepted event pin level
    logic                      pin_level_q;  // Accepted level one cycle ago

    // Bus decode
    rdct_bus_t bus;
    assign bus = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, wr: REG_WR_I, rd: REG_RD_I};
    wire hit_ctrl  = (bus.addr == RDCT_ADDR_CTRL);
    wire hit_io    = (bus.addr == RDCT_ADDR_IO);
    wire hit_mode  = (bus.addr == RDCT_ADDR_MODE);
    wire hit_count = (bus.addr == RDCT_ADDR_COUNT);
    wire wr_ctrl   = bus.wr & hit_ctrl;
    wire wr_io     = bus.wr & hit_io;
    wire wr_mode   = bus.wr & hit_mode;
    wire wr_count  = bus.wr & hit_count;
    wire force_stop = wr_ctrl & bus.wdata[RDCT_BIT_STOP];

    // The counter register needs one wait clock per access; flagged for the bus fabric
    assign BUS_WAIT_O = (bus.wr | bus.rd) & hit_count;

    // Mode and field decode
    wire [2:0] mode     = mode_sel.operating_mode_field;
    wire [2:0] src      = mode_sel.count_source_select;
    wire       pol      = io_ctl.io_polarity_select;
    wire       m_pulse  = (mode == RDCT_MODE_PULSE);
    wire       m_event  = (mode == RDCT_MODE_EVENT);
    wire       m_width  = (mode == RDCT_MODE_WIDTH);
    wire       m_period = (mode == RDCT_MODE_PERIOD);

    // Derived rates from the one divider
    wire div2_en  = presc[0];
    wire div8_en  = (presc[2:0] == 3'h7);
    wire div32_en = (presc == {RDCT_PRESC_W{1'b1}});

    // Filter sampling enable; no filter passes the pin straight through
    logic filt_en;
    always_comb begin
        unique case (io_ctl.input_filter_select)
            RDCT_FILT_CLK:   filt_en = 1'b1;
            RDCT_FILT_DIV8:  filt_en = div8_en;
            RDCT_FILT_DIV32: filt_en = div32_en;
            default:         filt_en = 1'b0;
        endcase
    end
    wire filt_all_one  = &filt_shift;
    wire filt_all_zero = ~|filt_shift;
    wire filt_off      = (io_ctl.input_filter_select == RDCT_FILT_NONE);

    // Accepted pin edges
    wire pin_rise = pin_level & ~pin_level_q;
    wire pin_fall = ~pin_level & pin_level_q;

    // Event count edge: one chosen edge, or both when edge select is set
    wire ev_edge = mode_sel.edge_count_select ? (pin_rise | pin_fall)
                                              : (pol ? pin_fall : pin_rise);

    // Count window in event mode
    logic gate_open;
    always_comb begin
        unique case (io_ctl.count_gate_select)
            RDCT_GATE_ALWAYS: gate_open = 1'b1;
            RDCT_GATE_EXTINT: gate_open = (EXT_INT_I == GATE_POLARITY_I);
            RDCT_GATE_TIMER:  gate_open = (GATE_TIMER_OUT_I == GATE_POLARITY_I);
            default:          gate_open = 1'b0;
        endcase
    end

    // Internal source tick; forbidden codes never tick
    logic clk_tick;
    always_comb begin
        unique case (src)
            RDCT_SRC_CLK:    clk_tick = 1'b1;
            RDCT_SRC_DIV8:   clk_tick = div8_en;
            RDCT_SRC_DIV2:   clk_tick = div2_en;
            RDCT_SRC_LOWOSC: clk_tick = LOW_SPEED_OSC_I & ~low_osc_q;
            RDCT_SRC_LINK:   clk_tick = LINK_EVENT_I;
            RDCT_SRC_SUB:    clk_tick = SUB_CLK_I & ~sub_clk_q;
            default:         clk_tick = 1'b0;
        endcase
    end

    // Event mode counts pin edges regardless of the source select
    wire src_tick = m_event ? ev_edge : clk_tick;

    // Width mode counts only while the pin sits at the measured level
    wire in_meas   = pol ? pin_level : ~pin_level;
    wire meas_ok   = ~m_width | in_meas;
    wire gate_ok   = ~m_event | gate_open;
    wire count_en  = count_status & src_tick & meas_ok & gate_ok & ~force_stop;
    wire underflow = count_en & (counter == 16'h0000);

    // Measurement complete events
    wire width_end  = m_width & count_status & (pol ? pin_fall : pin_rise);
    wire period_hit = m_period & count_status & (pol ? pin_fall : pin_rise);
    wire edge_event = width_end | period_hit;

    // Zero reload with a non-divided source, or in event mode, asks only once per run
    wire src_divided = (src == RDCT_SRC_DIV8) | (src == RDCT_SRC_DIV2);
    wire once_case   = (reload == 16'h0000) & (m_event | ~src_divided);
    wire req_fire    = underflow & ~(once_case & req_done);
    wire ev_idle_tgl = m_event & count_status & src_tick & ~gate_open & (reload == 16'h0000) & ~force_stop;
    // Next values of the counter and reload
    logic [15:0] next_counter;
    logic [15:0] next_reload;
    logic [1:0]  next_wr_stage;
    always_comb begin
        next_counter  = counter;
        next_reload   = reload;
        next_wr_stage = wr_stage;
        if (force_stop) begin
            next_counter  = RDCT_COUNT_RESET;
            next_wr_stage = 2'd0;
        end else if (wr_count && !start) begin
            // Stopped: both take the value at once
            next_reload   = bus.wdata;
            next_counter  = bus.wdata;
            next_wr_stage = 2'd0;
        end else begin
            if (underflow) begin
                next_counter = reload;
            end else if (count_en) begin
                next_counter = counter - 16'h0001;
            end
            // Running write: reload on one tick, counter on the next
            if (src_tick && wr_stage == 2'd1) begin
                next_reload   = reload_hold;
                next_wr_stage = 2'd2;
            end else if (src_tick && wr_stage == 2'd2) begin
                next_counter  = reload;
                next_wr_stage = 2'd0;
            end
            if (wr_count) begin
                next_wr_stage = 2'd1;
            end
        end
    end

    // Counter, reload and pending write
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            counter     <= RDCT_COUNT_RESET;
            reload      <= RDCT_COUNT_RESET;
            reload_hold <= RDCT_COUNT_RESET;
            wr_stage    <= 2'd0;
        end else begin
            counter  <= next_counter;
            reload   <= next_reload;
            wr_stage <= next_wr_stage;
            if (wr_count) begin
                reload_hold <= bus.wdata;
            end
        end
    end

    // Start bit and count status
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            start        <= RDCT_CTRL_RESET[RDCT_BIT_START];
            count_status <= RDCT_CTRL_RESET[RDCT_BIT_CSTAT];
        end else if (force_stop) begin
            start        <= 1'b0;
            count_status <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                start <= bus.wdata[RDCT_BIT_START];
            end
            // Status follows start only on a source tick
            if (src_tick) begin
                count_status <= start;
            end
        end
    end

    // Sticky flags: hardware set wins over a software clear, writing one leaves them
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            underflow_flag <= RDCT_CTRL_RESET[RDCT_BIT_UNDF];
            edge_flag      <= RDCT_CTRL_RESET[RDCT_BIT_EDGF];
        end else begin
            underflow_flag <= underflow | (underflow_flag &
                              ~(wr_ctrl & ~bus.wdata[RDCT_BIT_UNDF]));
            edge_flag      <= edge_event | (edge_flag &
                              ~(wr_ctrl & ~bus.wdata[RDCT_BIT_EDGF]));
        end
    end

    // I/O control and mode registers
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            io_ctl   <= rdct_io_t'(RDCT_IO_RESET);
            mode_sel <= rdct_mode_t'(RDCT_MODE_RESET);
        end else begin
            if (wr_io) begin
                io_ctl <= rdct_io_t'({bus.wdata[7:4], 1'b0, bus.wdata[2], 1'b0, bus.wdata[0]});
            end
            if (wr_mode) begin
                mode_sel <= rdct_mode_t'({1'b0, bus.wdata[6:0]});
            end
        end
    end

    // Pulse toggle; a forced stop or a mode write returns the pins to their initial level
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            toggle <= 1'b0;
        end else if (force_stop || wr_mode) begin
            toggle <= 1'b0;
        end else if (underflow || ev_idle_tgl) begin
            toggle <= ~toggle;
        end
    end

    // Zero-reload request memory, cleared whenever counting is stopped
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            req_done <= 1'b0;
        end else if (!count_status || force_stop) begin
            req_done <= 1'b0;
        end else if (req_fire) begin
            req_done <= 1'b1;
        end
    end

    // Requests: interrupt on every underflow or measurement event, transfer per request
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            TIMER_IRQ_O <= 1'b0;
            XFER_REQ_O  <= 1'b0;
        end else begin
            TIMER_IRQ_O <= underflow | edge_event;
            XFER_REQ_O  <= req_fire;
        end
    end

    // Prescaler and synchronous source edge history
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            presc     <= '0;
            low_osc_q <= 1'b0;
            sub_clk_q <= 1'b0;
        end else begin
            presc     <= presc + {{(RDCT_PRESC_W-1){1'b0}}, 1'b1};
            low_osc_q <= LOW_SPEED_OSC_I;
            sub_clk_q <= SUB_CLK_I;
        end
    end

    // Event pin filter: a level is accepted only after matching samples in a row
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            filt_shift  <= '0;
            pin_level   <= 1'b0;
            pin_level_q <= 1'b0;
        end else begin
            pin_level_q <= pin_level;
            if (filt_off) begin
                pin_level <= EVENT_IO_I;
            end else if (filt_en) begin
                filt_shift <= {filt_shift[FILTER_SAMPLES-2:0], EVENT_IO_I};
            end
            if (!filt_off && filt_all_one) begin
                pin_level <= 1'b1;
            end else if (!filt_off && filt_all_zero) begin
                pin_level <= 1'b0;
            end
        end
    end

    // Pins: pulse pin starts at the polarity level, event pin at its opposite
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PULSE_OUT_O      <= 1'b0;
            PULSE_OUT_OE_N_O <= 1'b1;
            EVENT_IO_O       <= 1'b1;
            EVENT_IO_OE_N_O  <= 1'b1;
        end else begin
            PULSE_OUT_O      <= pol ^ toggle;
            PULSE_OUT_OE_N_O <= ~io_ctl.pulse_output_enable;
            EVENT_IO_O       <= ~pol ^ toggle;
            // The event pin is an output only in pulse output mode
            EVENT_IO_OE_N_O  <= ~m_pulse;
        end
    end

    // Read mux; stop bit and reserved bits read zero, unmapped reads zero
    wire [15:0] rd_ctrl = {10'h000, underflow_flag, edge_flag, 1'b0, 1'b0, count_status, start};
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        if (hit_ctrl) begin
            next_rdata = rd_ctrl;
        end else if (hit_io) begin
            next_rdata = {8'h00, io_ctl};
        end else if (hit_mode) begin
            next_rdata = {8'h00, mode_sel};
        end else if (hit_count) begin
            next_rdata = counter;
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            REG_RDATA_O <= 16'h0000;
        end else if (bus.rd) begin
            REG_RDATA_O <= next_rdata;
        end else begin
            REG_RDATA_O <= 16'h0000;
        end
    end

endmodule

// ==== verification/rdct_timer_sva.sv ====
// Checker for the timer's register port, pin enables and request outputs
`timescale 1ns/1ns
module rdct_timer_sva
    import rdct_pkg::*;
(
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_N_I,
    // Register port
    input wire logic [19:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_RD_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic        BUS_WAIT_O,
    // Pins and requests
    input wire logic        EVENT_IO_OE_N_O,
    input wire logic        PULSE_OUT_OE_N_O,
    input wire logic        TIMER_IRQ_O,
    input wire logic        XFER_REQ_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic [2:0] mode;  // Last mode written, shadowed from the port
    // Decoded accesses
    wire wr_ctrl = REG_WR_I && REG_ADDR_I == RDCT_ADDR_CTRL;
    wire wr_io   = REG_WR_I && REG_ADDR_I == RDCT_ADDR_IO;
    wire wr_mode = REG_WR_I && REG_ADDR_I == RDCT_ADDR_MODE;
    wire oe_bit  = REG_WDATA_I[2];
    wire hit     = REG_ADDR_I inside {RDCT_ADDR_CTRL, RDCT_ADDR_IO, RDCT_ADDR_MODE, RDCT_ADDR_COUNT};
    // Mode shadow, so pin enables can be judged without seeing the body
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode <= RDCT_MODE_TIMER;
        end else if (wr_mode) begin
            mode <= REG_WDATA_I[2:0];
        end
    end
    sequence stop_wr_s;
        wr_ctrl && REG_WDATA_I[RDCT_BIT_STOP];
    endsequence
    sequence rd_ctrl_s;
        REG_RD_I && REG_ADDR_I == RDCT_ADDR_CTRL;
    endsequence
    sequence rd_count_s;
        REG_RD_I && REG_ADDR_I == RDCT_ADDR_COUNT;
    endsequence
    wait_count_a: assert property (BUS_WAIT_O == ((REG_WR_I || REG_RD_I) && REG_ADDR_I == RDCT_ADDR_COUNT))
        else $error("wait flag wrong");
    rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (REG_RD_I && !hit |=> REG_RDATA_O == 16'h0000)
        else $error("hole read not zero");
    ctrl_reserved_a: assert property (rd_ctrl_s |=> REG_RDATA_O[15:6] == 10'h000 && REG_RDATA_O[3:2] == 2'h0)
        else $error("stop or reserved bit reads one");
    stop_status_a: assert property (stop_wr_s ##2 rd_ctrl_s |=> REG_RDATA_O[1:0] == 2'h0)
        else $error("start or status left after stop");
    stop_ones_a: assert property (stop_wr_s ##2 rd_ctrl_s ##2 rd_count_s |=> REG_RDATA_O == RDCT_COUNT_RESET)
        else $error("counter not ones after stop");
    oe_follow_a: assert property (wr_io ##1 !wr_io |=> PULSE_OUT_OE_N_O == !$past(oe_bit, 2))
        else $error("pulse pin enable wrong");
    event_oe_a: assert property (mode != RDCT_MODE_PULSE && $stable(mode) |-> EVENT_IO_OE_N_O)
        else $error("event pin driven outside pulse mode");
    xfer_irq_a: assert property (XFER_REQ_O |-> TIMER_IRQ_O)
        else $error("request without underflow");
endmodule

bind rdct_timer rdct_timer_sva rdct_timer_sva_inst (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .BUS_WAIT_O(BUS_WAIT_O), .EVENT_IO_OE_N_O(EVENT_IO_OE_N_O),
    .PULSE_OUT_OE_N_O(PULSE_OUT_OE_N_O), .TIMER_IRQ_O(TIMER_IRQ_O), .XFER_REQ_O(XFER_REQ_O));

// ==== verification/rdct_pin_partner.sv ====
// External event source on the shared event pin
`timescale 1ns/1ns
module rdct_pin_partner (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic run_i,
    // Timer side of the pin
    input  wire logic dev_i,
    input  wire logic dev_oe_n_i,
    // Resolved pin and edge count
    output logic      pin_o,
    output int        rises_o
);
    logic       drv;  // Level the source drives
    logic [1:0] ph;   // Half period counter
    initial begin
        drv = 1'b0;
        ph = 2'h0;
        rises_o = 0;
    end
    // Toggles every fourth clock; slow enough for any filter-free sampling
    always @(posedge clk_i) begin
        if (run_i) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                drv <= !drv;
                rises_o <= rises_o + int'(!drv);
            end
        end
    end
    // Timer wins the wire while it drives
    assign pin_o = dev_oe_n_i ? drv : dev_i;
endmodule

// ==== verification/rdct_timer_tb.sv ====
// Self-checking bench for the reload down-counter timer
`timescale 1ns/1ns
module rdct_timer_tb;
    import rdct_pkg::*;
    logic        clk, rst_n, wr, rd, osc, sub, link, run;  // Bench-driven controls
    logic [19:0] addr;                                     // Register address
    logic [15:0] wdata, rdata, d, v;                       // Bus data and scratch
    logic        bwait, eo, eoe_n, po, poe_n, irq, xfer, pin;
    logic [7:0]  cyc;                                      // Slow source divider
    int          error_cnt, checked, xcnt, rises, k, i;
    logic [19:0] amap [5] = '{RDCT_ADDR_COUNT, RDCT_ADDR_CTRL, RDCT_ADDR_IO, RDCT_ADDR_MODE, 20'hF_02A3};
    logic [15:0] rval [5] = '{RDCT_COUNT_RESET, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [2:0]  srcs [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
    rdct_timer rdct_timer_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .BUS_WAIT_O(bwait),
        .LOW_SPEED_OSC_I(osc), .SUB_CLK_I(sub), .LINK_EVENT_I(link), .EXT_INT_I(1'b0),
        .GATE_TIMER_OUT_I(1'b0), .GATE_POLARITY_I(1'b0), .EVENT_IO_I(pin), .EVENT_IO_O(eo),
        .EVENT_IO_OE_N_O(eoe_n), .PULSE_OUT_O(po), .PULSE_OUT_OE_N_O(poe_n), .TIMER_IRQ_O(irq),
        .XFER_REQ_O(xfer));
    rdct_pin_partner rdct_pin_partner_inst (.clk_i(clk), .run_i(run), .dev_i(eo),
        .dev_oe_n_i(eoe_n), .pin_o(pin), .rises_o(rises));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Slow sources, random link events and request counting
    always @(posedge clk) begin
        cyc <= cyc + 8'h01;
        osc <= cyc[2];
        sub <= cyc[3];
        link <= 1'($urandom);
        if (xfer === 1'b1) xcnt <= xcnt + 1;
    end
    task automatic wr_reg(input logic [19:0] a, input logic [15:0] x);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [19:0] a, output logic [15:0] x);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdata;
        @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Zero reload gives a single request except on the divided clocks, and always in event mode
    function automatic logic exp_once(input logic [2:0] s, input logic ev);
        return ev || !(s == RDCT_SRC_DIV8 || s == RDCT_SRC_DIV2);
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog, several times the expected run length
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        k = $urandom(40716);
        {rst_n, wr, rd, run, addr, wdata, cyc, xcnt, error_cnt, checked} = '0;
        {osc, sub, link} = 3'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            rd_reg(amap[i], d);
            chk(d, rval[i]);
        end
        v = 16'($urandom);
        wr_reg(RDCT_ADDR_COUNT, v);
        rd_reg(RDCT_ADDR_COUNT, d);
        chk(d, v);
        // Pulse output, start high on the pulse pin and low on the event pin
        wr_reg(RDCT_ADDR_IO, 16'h0005);
        wr_reg(RDCT_ADDR_MODE, 16'(RDCT_MODE_PULSE));
        repeat (2) @(posedge clk);
        chk(16'({po, poe_n, eo, eoe_n}), 16'h0008);
        wr_reg(RDCT_ADDR_COUNT, 16'(4 + $urandom % 4));
        wr_reg(RDCT_ADDR_CTRL, 16'h0001);
        rd_reg(RDCT_ADDR_CTRL, d);
        chk(d & 16'h0003, 16'h0003);
        for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        chk(16'(po), 16'h0000);
        // Forced stop with a one written over the underflow flag
        wr_reg(RDCT_ADDR_CTRL, 16'h0024);
        rd_reg(RDCT_ADDR_CTRL, d);
        chk(d, 16'h0020);
        rd_reg(RDCT_ADDR_COUNT, d);
        chk(d, 16'hFFFF);
        chk(16'(po), 16'h0001);
        wr_reg(RDCT_ADDR_CTRL, 16'h0000);
        rd_reg(RDCT_ADDR_CTRL, d);
        chk(d, 16'h0000);
        // Zero reload across every count source
        foreach (srcs[j]) begin
            wr_reg(RDCT_ADDR_MODE, 16'({1'b0, srcs[j], 1'b0, RDCT_MODE_TIMER}));
            wr_reg(RDCT_ADDR_COUNT, 16'h0000);
            xcnt = 0;
            wr_reg(RDCT_ADDR_CTRL, 16'h0001);
            repeat (200) @(posedge clk);
            wr_reg(RDCT_ADDR_CTRL, 16'h0004);
            chk(16'(exp_once(srcs[j], 1'b0) ? xcnt : int'(xcnt > 1)), 16'h0001);
        end
        // Event count on rising pin edges, window always open
        wr_reg(RDCT_ADDR_IO, 16'h0000);
        wr_reg(RDCT_ADDR_MODE, 16'(RDCT_MODE_EVENT));
        v = 16'(20 + $urandom % 20);
        wr_reg(RDCT_ADDR_COUNT, v);
        wr_reg(RDCT_ADDR_CTRL, 16'h0001);
        k = rises;
        run <= 1'b1;
        repeat (80) @(posedge clk);
        run <= 1'b0;
        repeat (8) @(posedge clk);
        rd_reg(RDCT_ADDR_COUNT, d);
        chk(d, v - 16'(rises - k - 1));
        end_of_test();
    end
endmodule
